// ---- isab_pkg.sv ----
package isab_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 100000;
  localparam int SYSCLK_MIN_KHZ = 6000;
  localparam int SYSCLK_MAX_KHZ = 8330;
  // half period rounds up so the bus clock never passes its top rate
  localparam int SYSCLK_HALF_CYC =
    (CLK_KHZ + 2 * SYSCLK_MAX_KHZ - 1) / (2 * SYSCLK_MAX_KHZ);
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SYSCLK_HALF_CYC - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = 4'h0;

  // bus clocks of command time before ready is honoured
  localparam int WAIT_W = 3;
  localparam logic [WAIT_W-1:0] WAIT_16BIT = 3'h1;
  localparam logic [WAIT_W-1:0] WAIT_8BIT = 3'h4;
  localparam logic [WAIT_W-1:0] WAIT_ZERO = 3'h0;

  // ----------------------------------------------------------------
  // address layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int LA_HI = 23;
  localparam int LA_LO = 17;
  localparam int LA_W = LA_HI - LA_LO + 1;
  localparam int SA_HI = 19;
  localparam int SA_W = SA_HI + 1;
  localparam int IO_HI = 15;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    KIND_IO_RD = 3'h0,
    KIND_IO_WR = 3'h1,
    KIND_MEM_RD = 3'h2,
    KIND_MEM_WR = 3'h3,
    KIND_REFRESH = 3'h4
  } isab_kind_t;

  typedef struct packed
  {
    isab_kind_t kind;
    logic dma;
    logic fast;
    logic byte_hi;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } isab_req_t;

  typedef struct packed
  {
    logic wide;
    logic [DATA_W-1:0] data;
  } isab_rsp_t;

  // pins that arrive from the bus and need synchronising
  typedef struct packed
  {
    logic master_n;
    logic iochk_n;
    logic iocs16_n;
    logic iochrdy;
    logic [DATA_W-1:0] sd;
  } isab_pin_t;

  localparam isab_pin_t PIN_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 16'h0000};

endpackage

// ---- isab_fifo.sv ----
`timescale 1ns/100ps

module isab_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic rdy_q, rdy_d;
  logic push, pop;

  // ----------------------------------------------------------------
  // pointers and fill level
  // ----------------------------------------------------------------
  // ready is registered, so a full fifo refuses one cycle after filling
  always_comb
  begin
    push = in_valid && rdy_q;
    pop = out_valid && out_ready;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push)
    begin
      wr_d = (wr_q == PTR_LAST) ? '0 : AW'(wr_q + 1'b1);
    end
    if (pop)
    begin
      rd_d = (rd_q == PTR_LAST) ? '0 : AW'(rd_q + 1'b1);
    end
    if (push && !pop)
    begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end
    else if (pop && !push)
    begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
    rdy_d = (cnt_d != CNT_FULL);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  assign in_ready = rdy_q;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

endmodule

// ---- isab_bridge.sv ----
`timescale 1ns/100ps

// Summary of operation
// - address enable high throughout dma cycles
// - address enable high on refresh, low in reset
// - latch strobe marks address and enables valid
// - upper address stable through latch strobe fall
// - latch strobe held for dma, master; low reset
// - bus clock output between 6 and 8.33 MHz
// - ready low extends cycle; never driven here
// - 16-bit select makes io access sixteen bits
// - channel check raises nmi when enabled
// - io read command, high in reset
// - io write command, high in reset
// - upper lines select 16 Mbyte memory space
// - upper lines floated for fast dma types
// - system address mirrors upper lines on memory
// - io cycles drive system address bits above 15 as zero
// - system address driven only when bus owned
// - system address floated for fast dma types
// - byte high enable marks upper lane transfer
module isab_bridge (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  output logic req_ready,
  input wire isab_pkg::isab_req_t req,
  output logic rsp_valid,
  output isab_pkg::isab_rsp_t rsp,
  input wire logic nmi_en,
  input wire logic nmi_clr,
  output logic nmi,
  output logic sysclk,
  output logic bale,
  output logic aen,
  output logic sbhe_n_o,
  output logic sbhe_oe,
  output logic [isab_pkg::LA_W-1:0] la_o,
  output logic la_oe,
  output logic [isab_pkg::SA_W-1:0] sa_o,
  output logic sa_oe,
  output logic ior_n_o,
  output logic iow_n_o,
  output logic memr_n_o,
  output logic memw_n_o,
  output logic cmd_oe,
  output logic [isab_pkg::DATA_W-1:0] sd_o,
  output logic sd_oe,
  input wire logic [isab_pkg::DATA_W-1:0] sd_i,
  input wire logic iochrdy_i,
  input wire logic iocs16_n,
  input wire logic iochk_n,
  input wire logic master_n
);
  import isab_pkg::*;

  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_CMD = 5'h04,
    ST_WAIT = 5'h08,
    ST_END = 5'h10
  } isab_state_t;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  isab_pin_t pin_raw, sync0_q, sync1_q;

  assign pin_raw = '{master_n, iochk_n, iocs16_n, iochrdy_i, sd_i};

  // two stages; only sync1_q is looked at by the logic
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync0_q <= PIN_IDLE;
      sync1_q <= PIN_IDLE;
    end
    else
    begin
      sync0_q <= pin_raw;
      sync1_q <= sync0_q;
    end
  end

  // ----------------------------------------------------------------
  // bus clock divider
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_q, div_d;
  logic sysclk_q, sysclk_d;
  logic bus_edge;

  // toggle every half period; bus_edge marks each rising bus clock
  always_comb
  begin
    div_d = (div_q == DIV_LAST) ? DIV_ZERO : DIV_W'(div_q + 1'b1);
    sysclk_d = (div_q == DIV_LAST) ? !sysclk_q : sysclk_q;
    bus_edge = (div_q == DIV_LAST) && !sysclk_q;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_q <= DIV_ZERO;
      sysclk_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      sysclk_q <= sysclk_d;
    end
  end

  // ----------------------------------------------------------------
  // posted request fifo
  // ----------------------------------------------------------------
  logic fifo_valid, fifo_pop;
  isab_req_t fifo_data;

  isab_fifo #(
    .WIDTH($bits(isab_req_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ----------------------------------------------------------------
  // cycle engine
  // ----------------------------------------------------------------
  isab_state_t st_q, st_d;
  isab_req_t cur_q, cur_d;
  logic [WAIT_W-1:0] wait_q, wait_d;
  logic wide_q, wide_d;
  logic bale_q, bale_d, aen_q, aen_d;
  logic sbhe_q, sbhe_d, addr_oe_q, addr_oe_d;
  logic own_q, own_d;
  logic [LA_W-1:0] la_q, la_d;
  logic [SA_W-1:0] sa_q, sa_d;
  logic ior_q, ior_d, iow_q, iow_d, memr_q, memr_d, memw_q, memw_d;
  logic [DATA_W-1:0] sd_q, sd_d;
  logic sd_oe_q, sd_oe_d;
  logic rsp_valid_q, rsp_valid_d;
  isab_rsp_t rsp_q, rsp_d;
  logic ext_master, is_io, is_wr;

  always_comb
  begin
    ext_master = !sync1_q.master_n;
    is_io = (cur_q.kind == KIND_IO_RD) || (cur_q.kind == KIND_IO_WR);
    is_wr = (fifo_data.kind == KIND_IO_WR) ||
      (fifo_data.kind == KIND_MEM_WR);
    st_d = st_q;
    cur_d = cur_q;
    wait_d = wait_q;
    wide_d = wide_q;
    bale_d = bale_q;
    aen_d = aen_q;
    sbhe_d = sbhe_q;
    addr_oe_d = addr_oe_q;
    own_d = own_q;
    la_d = la_q;
    sa_d = sa_q;
    ior_d = ior_q;
    iow_d = iow_q;
    memr_d = memr_q;
    memw_d = memw_q;
    sd_d = sd_q;
    sd_oe_d = sd_oe_q;
    rsp_valid_d = 1'b0;
    rsp_d = rsp_q;
    fifo_pop = 1'b0;
    unique case (st_q)
      ST_IDLE:
      begin
        // an outside master owns the bus: float and hold the strobe
        bale_d = ext_master;
        own_d = !ext_master;
        addr_oe_d = addr_oe_q && !ext_master;
        if (bus_edge && fifo_valid && !ext_master)
        begin
          fifo_pop = 1'b1;
          cur_d = fifo_data;
          st_d = ST_ADDR;
          bale_d = 1'b1;
          aen_d = fifo_data.dma || (fifo_data.kind == KIND_REFRESH);
          la_d = fifo_data.addr[LA_HI:LA_LO];
          sa_d = fifo_data.addr[SA_HI:0];
          if ((fifo_data.kind == KIND_IO_RD) ||
            (fifo_data.kind == KIND_IO_WR))
          begin
            sa_d[SA_HI:IO_HI+1] = '0;
          end
          // refresh never uses the upper lane
          sbhe_d = (fifo_data.kind == KIND_REFRESH) ||
            !fifo_data.byte_hi;
          addr_oe_d = !(fifo_data.dma && fifo_data.fast);
          sd_d = fifo_data.data;
          sd_oe_d = is_wr;
        end
      end
      ST_ADDR:
      begin
        if (bus_edge)
        begin
          // strobe falls, except on dma, with address still held, so receivers latch
          bale_d = cur_q.dma;
          ior_d = (cur_q.kind != KIND_IO_RD);
          iow_d = (cur_q.kind != KIND_IO_WR);
          memr_d = !((cur_q.kind == KIND_MEM_RD) ||
            (cur_q.kind == KIND_REFRESH));
          memw_d = (cur_q.kind != KIND_MEM_WR);
          wide_d = is_io ? !sync1_q.iocs16_n : 1'b1;
          wait_d = (is_io && sync1_q.iocs16_n) ? WAIT_8BIT : WAIT_16BIT;
          st_d = ST_CMD;
        end
      end
      ST_CMD:
      begin
        if (bus_edge)
        begin
          if (wait_q == WAIT_ZERO)
          begin
            st_d = ST_WAIT;
          end
          else
          begin
            wait_d = WAIT_W'(wait_q - 1'b1);
          end
        end
      end
      ST_WAIT:
      begin
        // ready sampled once per bus clock; low adds a wait state
        if (bus_edge && sync1_q.iochrdy)
        begin
          ior_d = 1'b1;
          iow_d = 1'b1;
          memr_d = 1'b1;
          memw_d = 1'b1;
          sd_oe_d = 1'b0;
          bale_d = 1'b0;
          aen_d = 1'b0;
          rsp_d = '{wide_q, sync1_q.sd};
          st_d = ST_END;
        end
      end
      ST_END:
      begin
        rsp_valid_d = 1'b1;
        st_d = ST_IDLE;
      end
      default:
      begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // reset values: strobe and enable low, commands driven high
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= ST_IDLE;
      cur_q <= '0;
      wait_q <= WAIT_ZERO;
      wide_q <= 1'b0;
      bale_q <= 1'b0;
      aen_q <= 1'b0;
      sbhe_q <= 1'b1;
      addr_oe_q <= 1'b0;
      own_q <= 1'b1;
      la_q <= '0;
      sa_q <= '0;
      ior_q <= 1'b1;
      iow_q <= 1'b1;
      memr_q <= 1'b1;
      memw_q <= 1'b1;
      sd_q <= '0;
      sd_oe_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      cur_q <= cur_d;
      wait_q <= wait_d;
      wide_q <= wide_d;
      bale_q <= bale_d;
      aen_q <= aen_d;
      sbhe_q <= sbhe_d;
      addr_oe_q <= addr_oe_d;
      own_q <= own_d;
      la_q <= la_d;
      sa_q <= sa_d;
      ior_q <= ior_d;
      iow_q <= iow_d;
      memr_q <= memr_d;
      memw_q <= memw_d;
      sd_q <= sd_d;
      sd_oe_q <= sd_oe_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_q <= rsp_d;
    end
  end

  // ----------------------------------------------------------------
  // channel check to nmi
  // ----------------------------------------------------------------
  logic nmi_q, nmi_d;

  // sticky; a new check in the clear cycle wins over the clear
  always_comb
  begin
    nmi_d = nmi_q;
    if (nmi_clr)
    begin
      nmi_d = 1'b0;
    end
    if (nmi_en && !sync1_q.iochk_n)
    begin
      nmi_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      nmi_q <= 1'b0;
    end
    else
    begin
      nmi_q <= nmi_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sysclk = sysclk_q;
  assign bale = bale_q;
  assign aen = aen_q;
  assign sbhe_n_o = sbhe_q;
  assign sbhe_oe = own_q;
  assign la_o = la_q;
  assign la_oe = addr_oe_q;
  assign sa_o = sa_q;
  assign sa_oe = addr_oe_q;
  assign ior_n_o = ior_q;
  assign iow_n_o = iow_q;
  assign memr_n_o = memr_q;
  assign memw_n_o = memw_q;
  assign cmd_oe = own_q;
  assign sd_o = sd_q;
  assign sd_oe = sd_oe_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp = rsp_q;
  assign nmi = nmi_q;

endmodule

// ---- isab_bridge_asserts.sv ----
`timescale 1ns/100ps
// ----
// bus timing checks
// ----
module isab_bridge_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic nmi_en,
  input wire logic nmi,
  input wire logic sysclk,
  input wire logic bale,
  input wire logic aen,
  input wire logic [isab_pkg::LA_W-1:0] la_o,
  input wire logic [isab_pkg::SA_W-1:0] sa_o,
  input wire logic sa_oe,
  input wire logic ior_n_o,
  input wire logic iow_n_o,
  input wire logic memr_n_o,
  input wire logic memw_n_o,
  input wire logic iochrdy_i,
  input wire logic iochk_n,
  input wire logic master_n
);
  import isab_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // strobe groups, active high
  wire io_lo = !ior_n_o || !iow_n_o;
  wire mem_lo = !memr_n_o || !memw_n_o;
  rst_idle_a: assert property ($rose(nrst) |->
    !aen && !bale && ior_n_o && iow_n_o) else $error("busy after reset");
  one_cmd_a: assert property (
    $onehot0({!ior_n_o, !iow_n_o, !memr_n_o, !memw_n_o}))
    else $error("two cmds");
  cmd_sync_a: assert property (
    $changed({ior_n_o, iow_n_o, memr_n_o, memw_n_o}) |->
    $rose(sysclk)) else $error("command off bus clock");
  clk_half_a: assert property ($rose(sysclk) |->
    sysclk [*6] ##[1:3] !sysclk) else $error("bus clock rate");
  io_addr_a: assert property (io_lo && sa_oe |->
    sa_o[19:16] == 4'h0) else $error("io upper address");
  mem_mirror_a: assert property (mem_lo && sa_oe && !aen |->
    sa_o[19:17] == la_o[2:0]) else $error("address mirror");
  ext_own_a: assert property ($fell(master_n) && !io_lo && !mem_lo |->
    ##[1:20] (bale && !sa_oe)) else $error("master not given bus");
  rdy_hold_a: assert property (!iochrdy_i [*4] ##0 io_lo |=> io_lo)
    else $error("wait state ignored");
  nmi_set_a: assert property ((!iochk_n && nmi_en) [*3] |=> nmi)
    else $error("nmi missing");
  nmi_why_a: assert property ($rose(nmi) |->
    $past(nmi_en) && !$past(iochk_n, 3)) else $error("nmi without cause");
  // main scenarios reached
  cover property (io_lo && !iochrdy_i);
  cover property (aen && mem_lo);
  cover property ($rose(nmi));
endmodule
bind isab_bridge isab_bridge_asserts u_chk (.clk, .nrst, .nmi_en, .nmi,
  .sysclk, .bale, .aen, .la_o, .sa_o, .sa_oe, .ior_n_o, .iow_n_o,
  .memr_n_o, .memw_n_o, .iochrdy_i, .iochk_n, .master_n);

// ---- isab_slave_model.sv ----
`timescale 1ns/100ps
// ----
// behavioural bus slave
// ----
module isab_slave_model (
  input wire logic clk,
  input wire logic [7:0] wait_clks,
  input wire logic bale,
  input wire logic aen,
  input wire logic sbhe_n_o,
  input wire logic [isab_pkg::LA_W-1:0] la_o,
  input wire logic la_oe,
  input wire logic [isab_pkg::SA_W-1:0] sa_o,
  input wire logic sa_oe,
  input wire logic [3:0] cmd_n,
  input wire logic [isab_pkg::DATA_W-1:0] sd_o,
  input wire logic sd_oe,
  output logic [isab_pkg::DATA_W-1:0] sd_i,
  output logic iochrdy_i,
  output logic iocs16_n,
  output logic obs_stb = 1'b0,
  output logic [48:0] obs
);
  import isab_pkg::*;
  logic [15:0] last_q = 16'h0000;
  logic [6:0] la_q = 7'h00;
  logic [7:0] wcnt_q = 8'h00;
  logic cmd_q = 1'b0;
  logic bale_q = 1'b0;
  // floated address reads as zero, so nothing leans on stale values
  wire cmd_lo = cmd_n != 4'hF;
  wire cmd_go = cmd_lo && !cmd_q;
  wire [6:0] la_w = la_oe ? la_o : 7'h00;
  wire [19:0] sa_w = sa_oe ? sa_o : 20'h00000;
  assign iocs16_n = !(sa_oe && sa_o[15]);
  assign iochrdy_i = wcnt_q == 8'h00;
  // data lanes: reads return the address xor A5C3; otherwise undriven bus shows the inverse of its last level
  always_comb
  begin
    if (sd_oe)
      sd_i = sd_o;
    else if (!cmd_n[3] || !cmd_n[1])
      sd_i = sa_w[15:0] ^ 16'hA5C3;
    else
      sd_i = ~last_q;
  end
  // latch upper lines on strobe fall, note each command start
  always_ff @(posedge clk)
  begin
    last_q <= sd_i;
    cmd_q <= cmd_lo;
    bale_q <= bale;
    obs_stb <= cmd_go;
    if (bale_q && !bale)
      la_q <= la_w;
    if (cmd_go)
      wcnt_q <= wait_clks;
    else if (wcnt_q != 8'h00)
      wcnt_q <= wcnt_q - 8'h01;
    if (cmd_go)
      obs <= {cmd_n, aen, sbhe_n_o, (bale || bale_q) ? la_w : la_q, sa_w,
        (!cmd_n[2] || !cmd_n[0]) ? sd_i : 16'h0000};
  end
endmodule

// ---- isab_bridge_tb.sv ----
`timescale 1ns/100ps
module isab_bridge_tb;
  import isab_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  isab_req_t req = '0;
  logic nmi_en = 1'b0, nmi_clr = 1'b0, iochk_n = 1'b1, master_n = 1'b1;
  logic [7:0] wait_clks = 8'h00;
  logic req_ready, rsp_valid, nmi, sysclk, bale, aen, sbhe_n_o, sbhe_oe;
  logic la_oe, sa_oe, ior_n_o, iow_n_o, memr_n_o, memw_n_o, cmd_oe, sd_oe;
  logic iochrdy_i, iocs16_n, obs_stb;
  logic [LA_W-1:0] la_o;
  logic [SA_W-1:0] sa_o;
  logic [DATA_W-1:0] sd_o, sd_i;
  logic [48:0] obs;
  isab_rsp_t rsp;
  logic [48:0] bus_q[$], bmsk_q[$];
  logic [16:0] rsp_q[$], rmsk_q[$];
  logic [3:0] cmds[5] = '{4'h7, 4'hB, 4'hD, 4'hE, 4'hD};
  int err_count = 0, checked = 0, refused = 0, rsp_n = 0, n;
  always #5 clk = ~clk;
  isab_bridge u_dut (.clk, .nrst, .req_valid, .req_ready, .req, .rsp_valid,
    .rsp, .nmi_en, .nmi_clr, .nmi, .sysclk, .bale, .aen, .sbhe_n_o, .sbhe_oe,
    .la_o, .la_oe, .sa_o, .sa_oe, .ior_n_o, .iow_n_o, .memr_n_o, .memw_n_o,
    .cmd_oe, .sd_o, .sd_oe, .sd_i, .iochrdy_i, .iocs16_n, .iochk_n,
    .master_n);
  isab_slave_model u_slave (.clk, .wait_clks, .bale, .aen, .sbhe_n_o, .la_o,
    .la_oe, .sa_o, .sa_oe, .cmd_n({ior_n_o, iow_n_o, memr_n_o, memw_n_o}),
    .sd_o, .sd_oe, .sd_i, .iochrdy_i, .iocs16_n, .obs_stb, .obs);
  // ----
  // checking
  // ----
  task automatic close_out();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic cmp_bus(input logic [48:0] g, e, k);
    chk((g & k) === (e & k), "bus cycle mismatch");
  endtask
  task automatic cmp_rsp(input logic [16:0] g, e, k);
    chk((g & k) === (e & k), "response mismatch");
  endtask
  // results are matched oldest first against the notes
  always @(posedge clk)
  begin
    if (obs_stb === 1'b1)
      cmp_bus(obs, bus_q.pop_front(), bmsk_q.pop_front());
    if (rsp_valid === 1'b1)
    begin
      rsp_n++;
      cmp_rsp(rsp, rsp_q.pop_front(), rmsk_q.pop_front());
    end
  end
  // ----
  // stimulus
  // ----
  task automatic send(input isab_kind_t k, input logic d, f, h,
    input logic [23:0] a, input logic [15:0] w);
    logic io, rf, fd, rd;
    logic [19:0] s;
    io = k < KIND_MEM_RD;
    rf = k == KIND_REFRESH;
    fd = d && f;
    rd = k == KIND_IO_RD || k == KIND_MEM_RD;
    s = fd ? 20'h00000 : io ? {4'h0, a[15:0]} : a[19:0];
    bus_q.push_back({cmds[int'(k)], d || rf, rf || !h,
      (fd || io) ? 7'h00 : a[23:17], s,
      (k == KIND_IO_WR || k == KIND_MEM_WR) ? w : 16'h0000});
    bmsk_q.push_back({6'h3F, (io || rf) ? 7'h00 : 7'h7F,
      rf ? 20'h00000 : 20'hFFFFF, 16'hFFFF});
    rsp_q.push_back({io ? a[15] : 1'b1, s[15:0] ^ 16'hA5C3});
    rmsk_q.push_back({!rf, rd ? 16'hFFFF : 16'h0000});
    @(negedge clk);
    req_valid = 1'b1;
    req = '{k, d, f, h, a, w};
    @(posedge clk);
    while (req_ready !== 1'b1)
    begin
      refused++;
      @(posedge clk);
    end
  endtask
  task automatic drain();
    for (int i = 0; i < 30000 && rsp_q.size() != 0; i++)
      @(posedge clk);
    chk(rsp_q.size() == 0 && bus_q.size() == 0, "cycles left over");
    repeat (4) @(negedge clk);
  endtask
  // back to back requests, the kinds in order for the first five, then random ones
  task automatic batch(input int cnt);
    isab_kind_t k;
    logic d;
    for (int i = 0; i < cnt; i++)
    begin
      k = isab_kind_t'(i < 5 ? i : $urandom_range(4, 0));
      d = k inside {KIND_MEM_RD, KIND_MEM_WR} && 1'($urandom_range(1, 0));
      send(k, d, 1'($urandom_range(1, 0)), 1'($urandom_range(1, 0)),
        24'($urandom()), 16'($urandom()));
    end
    @(negedge clk);
    req_valid = 1'b0;
    drain();
  endtask
  initial
  begin
    void'($urandom(32'hF00B45E4));
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    batch(24);
    chk(refused > 0, "fifo never refused");
    wait_clks = 8'h64; // slow slave stretches every cycle
    batch(6);
    master_n = 1'b0;
    repeat (40) @(negedge clk);
    send(KIND_IO_WR, 1'b0, 1'b0, 1'b1, 24'h008345, 16'h1234);
    @(negedge clk);
    req_valid = 1'b0;
    n = rsp_n;
    repeat (300) @(negedge clk);
    chk(rsp_n == n && bale === 1'b1, "bus not yielded");
    chk({sa_oe, la_oe, cmd_oe, sbhe_oe} === 4'h0, "bus not floated");
    master_n = 1'b1;
    drain();
    iochk_n = 1'b0;
    repeat (8) @(negedge clk);
    chk(nmi === 1'b0, "nmi while disabled");
    nmi_en = 1'b1;
    repeat (8) @(negedge clk);
    chk(nmi === 1'b1, "nmi not raised");
    iochk_n = 1'b1;
    nmi_clr = 1'b1;
    repeat (4) @(negedge clk);
    nmi_clr = 1'b0;
    @(negedge clk);
    chk(nmi === 1'b0, "nmi not cleared");
    nrst = 1'b0;
    @(negedge clk);
    chk(!aen && !bale, "reset strobes");
    chk(ior_n_o && iow_n_o && cmd_oe, "reset commands");
    chk(!sa_oe && !la_oe && !sd_oe, "reset address");
    nrst = 1'b1;
    batch(2);
    close_out();
  end
  // hang guard
  initial
  begin
    #500000;
    err_count++;
    close_out();
  end
endmodule
